// file: rtl/pvm_regs.sv
// vendor management register bank of the 10/100 transceiver
`timescale 1ns/1ps
`default_nettype none
`include "pvm_cfg.svh"

module pvm_regs #(
    parameter int ENERGY_TMO_CYC = `PVM_ENERGY_TMO_CYC,
    parameter logic [2:0] MODE_STRAP = 3'h7,
    parameter logic [4:0] ADDR_STRAP = `PVM_ADDR_RST
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic soft_reset,
    input wire pvm_pkg::pvm_req_t mgmt_req,
    output logic [15:0] mgmt_rdata,
    input wire pvm_pkg::pvm_line_t line_in,
    input wire logic tx_active,
    input wire logic rx_active,
    output logic [4:0] mgmt_device_address,
    output pvm_pkg::pvm_cfg_t mode_cfg,
    output logic energy_detect_powerdown_enable,
    output logic rx_pll_reference_hold,
    output logic crs,
    output logic mgmt_irq
);
    import pvm_pkg::*;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // line status comes from the analog side, so it is retimed
    pvm_line_t line_s1_reg;
    pvm_line_t line_reg;
    logic [1:0] txrx_s1_reg;
    logic [1:0] txrx_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            line_s1_reg <= '0;
            line_reg <= '0;
            txrx_s1_reg <= 2'h0;
            txrx_reg <= 2'h0;
        end else begin
            line_s1_reg <= line_in;
            line_reg <= line_s1_reg;
            txrx_s1_reg <= {tx_active, rx_active};
            txrx_reg <= txrx_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // write decode and interrupt-source read decode
    // ------------------------------------------------------------
    function automatic logic hit(input pvm_req_t r, input logic [4:0] i);
        hit = r.we && (r.idx == i);
    endfunction

    logic wr_energy;
    logic wr_modes;
    logic wr_ind;
    logic wr_mask;
    logic rd_isrc;

    assign wr_energy = hit(mgmt_req, `PVM_IDX_ENERGY);
    assign wr_modes = hit(mgmt_req, `PVM_IDX_MODES);
    assign wr_ind = hit(mgmt_req, `PVM_IDX_IND);
    assign wr_mask = hit(mgmt_req, `PVM_IDX_IMASK);
    assign rd_isrc = mgmt_req.re && (mgmt_req.idx == `PVM_IDX_ISRC);

    // ------------------------------------------------------------
    // control bits
    // ------------------------------------------------------------
    logic edpd_reg;
    logic pll_hold_reg;
    logic [7:0] mask_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_n || soft_reset) begin
            edpd_reg <= 1'b0;
            pll_hold_reg <= 1'b0;
            mask_reg <= 8'h00;
        end else begin
            if (wr_energy) begin
                edpd_reg <= mgmt_req.wdata[`PVM_EDPD_BIT];
            end
            if (wr_ind) begin
                pll_hold_reg <= mgmt_req.wdata[`PVM_HOLD_BIT];
            end
            if (wr_mask) begin
                mask_reg <= mgmt_req.wdata[7:0];
            end
        end
    end

    assign energy_detect_powerdown_enable = edpd_reg;
    assign rx_pll_reference_hold = pll_hold_reg;

    // ------------------------------------------------------------
    // mode and address, kept over soft reset
    // ------------------------------------------------------------
    logic [2:0] mode_reg;
    logic [4:0] addr_reg;
    logic [7:0] modes_hi_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            // hard reset returns to the straps, soft reset does not
            mode_reg <= MODE_STRAP;
            addr_reg <= ADDR_STRAP;
            modes_hi_reg <= 8'h00;
        end else if (wr_modes) begin
            modes_hi_reg <= mgmt_req.wdata[15:8];
            mode_reg <= mgmt_req.wdata[7:5];
            addr_reg <= mgmt_req.wdata[4:0];
        end
    end

    // straps caught on the first clock after hard reset release
    logic strap_done_reg;
    logic use_strap;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            strap_done_reg <= 1'b0;
        end else begin
            strap_done_reg <= 1'b1;
        end
    end
    assign use_strap = !strap_done_reg && !wr_modes;

    logic [2:0] mode_eff;
    logic [4:0] addr_eff;
    assign mode_eff = strap_done_reg ? mode_reg : MODE_STRAP;
    assign addr_eff = strap_done_reg ? addr_reg : ADDR_STRAP;
    assign mgmt_device_address = addr_eff;

    logic [2:0] mode_q_reg;
    logic [4:0] addr_q_reg;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mode_q_reg <= 3'h0;
            addr_q_reg <= 5'h00;
        end else if (use_strap) begin
            mode_q_reg <= MODE_STRAP;
            addr_q_reg <= ADDR_STRAP;
        end else begin
            mode_q_reg <= mode_eff;
            addr_q_reg <= addr_eff;
        end
    end

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    function automatic pvm_cfg_t decode_mode(input logic [2:0] m);
        pvm_cfg_t c;
        c = '0;
        case (pvm_mode_t'(m))
            PVM_M_10H: c.ctrl0_bits = 4'h0;
            PVM_M_10F: c.ctrl0_bits = 4'h1;
            PVM_M_100H: begin
                c.ctrl0_bits = 4'h8;
                c.crs_on_tx = 1'b1;
            end
            PVM_M_100F: c.ctrl0_bits = 4'h9;
            PVM_M_AN100H: begin
                c.ctrl0_bits = 4'hc;
                c.adv_bits = 4'h4;
                c.autoneg_enable = 1'b1;
                c.crs_on_tx = 1'b1;
            end
            PVM_M_RPT: begin
                c.ctrl0_bits = 4'hc;
                c.adv_bits = 4'h4;
                c.autoneg_enable = 1'b1;
            end
            PVM_M_ALL: begin
                c.ctrl0_bits = 4'h4;
                c.adv_bits = 4'hf;
                c.autoneg_enable = 1'b1;
                c.crs_on_tx = 1'b1;
            end
            default: c = '0; // reserved code
        endcase
        decode_mode = c;
    endfunction

    pvm_cfg_t cfg_reg;
    pvm_cfg_t cfg_next;
    logic crs_reg;
    assign cfg_next = decode_mode(mode_eff);
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cfg_reg <= '0;
            crs_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            // carrier sense: receive always, transmit per mode
            crs_reg <= txrx_reg[0] ||
                (txrx_reg[1] && cfg_next.crs_on_tx);
        end
    end
    assign mode_cfg = cfg_reg;
    assign crs = crs_reg;

    // ------------------------------------------------------------
    // energy detect
    // ------------------------------------------------------------
    logic energy_reg;
    logic [31:0] quiet_cnt_reg;
    logic energy_prev_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            energy_reg <= 1'b1;
            quiet_cnt_reg <= 32'h0;
        end else if (line_reg.energy_seen) begin
            energy_reg <= 1'b1;
            quiet_cnt_reg <= 32'h0;
        end else if (quiet_cnt_reg >= 32'(ENERGY_TMO_CYC - 1)) begin
            energy_reg <= 1'b0;
        end else begin
            quiet_cnt_reg <= quiet_cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            energy_prev_reg <= 1'b1;
        end else begin
            energy_prev_reg <= energy_reg;
        end
    end

    // ------------------------------------------------------------
    // latched source flags
    // ------------------------------------------------------------
    logic [7:0] ev;
    logic prev_an_reg;
    logic prev_link_reg;
    logic prev_rf_reg;
    logic prev_ack_reg;
    logic prev_pdf_reg;
    logic prev_page_reg;
    logic [7:0] isrc_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prev_an_reg <= 1'b0;
            prev_link_reg <= 1'b0;
            prev_rf_reg <= 1'b0;
            prev_ack_reg <= 1'b0;
            prev_pdf_reg <= 1'b0;
            prev_page_reg <= 1'b0;
        end else begin
            prev_an_reg <= line_reg.autoneg_done;
            prev_link_reg <= line_reg.link_up;
            prev_rf_reg <= line_reg.remote_fault;
            prev_ack_reg <= line_reg.partner_ack;
            prev_pdf_reg <= line_reg.parallel_fault;
            prev_page_reg <= line_reg.page_rx;
        end
    end

    always_comb begin
        ev = 8'h00;
        ev[7] = energy_reg && !energy_prev_reg;
        ev[6] = line_reg.autoneg_done && !prev_an_reg;
        ev[5] = line_reg.remote_fault && !prev_rf_reg;
        ev[4] = !line_reg.link_up && prev_link_reg;
        ev[3] = line_reg.partner_ack && !prev_ack_reg;
        ev[2] = line_reg.parallel_fault && !prev_pdf_reg;
        ev[1] = line_reg.page_rx && !prev_page_reg;
    end

    // new events win over the clear caused by a read
    always_ff @(posedge sys_clk) begin
        if (!rst_n || soft_reset) begin
            isrc_reg <= 8'h00;
        end else if (rd_isrc) begin
            isrc_reg <= ev;
        end else begin
            isrc_reg <= isrc_reg | ev;
        end
    end

    assign mgmt_irq = |(isrc_reg & mask_reg);

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [15:0] rd_next;
    always_comb begin
        rd_next = 16'h0000;
        case (mgmt_req.idx)
            `PVM_IDX_ENERGY: begin
                rd_next[`PVM_EDPD_BIT] = edpd_reg;
                rd_next[`PVM_ENERGY_BIT] = energy_reg;
            end
            `PVM_IDX_MODES:
                rd_next = {modes_hi_reg, mode_q_reg, addr_q_reg};
            `PVM_IDX_IND: begin
                rd_next[`PVM_HOLD_BIT] = pll_hold_reg;
                rd_next[`PVM_POL_BIT] = line_reg.polarity_reversed;
                rd_next[3:0] = `PVM_IND_CONST;
            end
            `PVM_IDX_ISRC: rd_next[7:0] = isrc_reg;
            `PVM_IDX_IMASK: rd_next[7:0] = mask_reg;
            `PVM_IDX_LINK: begin
                // done only when negotiation is enabled
                rd_next[12] = cfg_reg.autoneg_enable && line_reg.autoneg_done;
                rd_next[11:5] = `PVM_LINK_RSVD;
                rd_next[4:2] = line_reg.resolved_speed_duplex;
            end
            default: rd_next = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mgmt_rdata <= 16'h0000;
        end else if (mgmt_req.re) begin
            mgmt_rdata <= rd_next;
        end
    end

endmodule
`default_nettype wire

// file: rtl/pvm_cfg.svh
// register offsets, field positions, reset values and timing counts
`ifndef PVM_CFG_SVH
`define PVM_CFG_SVH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define PVM_IDX_ENERGY 5'h11
`define PVM_IDX_MODES 5'h12
`define PVM_IDX_IND 5'h1b
`define PVM_IDX_ISRC 5'h1d
`define PVM_IDX_IMASK 5'h1e
`define PVM_IDX_LINK 5'h1f

// ----------------------------------------------------------------
// field positions and constants
// ----------------------------------------------------------------
`define PVM_EDPD_BIT 13
`define PVM_ENERGY_BIT 1
`define PVM_HOLD_BIT 10
`define PVM_POL_BIT 4
`define PVM_IND_CONST 4'hb
`define PVM_LINK_RSVD 7'h02
`define PVM_ADDR_RST 5'h01
`define PVM_ISRC_WIDTH 8

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PVM_CLK_HZ 40000000
`define PVM_ENERGY_TMO_MS 256
`define PVM_ENERGY_TMO_CYC ((`PVM_CLK_HZ / 1000) * `PVM_ENERGY_TMO_MS)

`endif

// file: rtl/pvm_pkg.sv
// types for the vendor management register bank
package pvm_pkg;

    typedef enum logic [2:0] {
        PVM_M_10H, PVM_M_10F, PVM_M_100H, PVM_M_100F,
        PVM_M_AN100H, PVM_M_RPT, PVM_M_RSVD, PVM_M_ALL
    } pvm_mode_t;

    typedef struct packed {
        logic we;
        logic re;
        logic [4:0] idx;
        logic [15:0] wdata;
    } pvm_req_t;

    typedef struct packed {
        logic energy_seen;
        logic autoneg_done;
        logic remote_fault;
        logic link_up;
        logic partner_ack;
        logic parallel_fault;
        logic page_rx;
        logic polarity_reversed;
        logic [2:0] resolved_speed_duplex;
    } pvm_line_t;

    typedef struct packed {
        logic [3:0] ctrl0_bits;
        logic [3:0] adv_bits;
        logic autoneg_enable;
        logic crs_on_tx;
    } pvm_cfg_t;

endpackage

// file: testbench/pvm_regs_checker.sv
// port assertions for the vendor register bank
`timescale 1ns/1ps
`default_nettype none
module pvm_regs_checker
    import pvm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic soft_reset,
    input wire pvm_pkg::pvm_req_t mgmt_req,
    input wire logic [15:0] mgmt_rdata,
    input wire logic rx_active,
    input wire logic [4:0] mgmt_device_address,
    input wire pvm_pkg::pvm_cfg_t mode_cfg,
    input wire logic energy_detect_powerdown_enable,
    input wire logic rx_pll_reference_hold,
    input wire logic crs,
    input wire logic mgmt_irq
);
    // ----
    // relations
    // ----
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire logic rd_now = mgmt_req.re && !mgmt_req.we;
    a_edpd_write:
        assert property (mgmt_req.we && mgmt_req.idx == 5'h11 && !soft_reset
            |=> energy_detect_powerdown_enable == $past(mgmt_req.wdata[13]))
        else $error("power-down enable not written");
    a_pll_write:
        assert property (mgmt_req.we && mgmt_req.idx == 5'h1b && !soft_reset
            |=> rx_pll_reference_hold == $past(mgmt_req.wdata[10]))
        else $error("pll hold not written");
    a_ind_const:
        assert property (rd_now && mgmt_req.idx == 5'h1b
            |=> mgmt_rdata[3:0] == 4'hb)
        else $error("indication low bits wrong");
    a_forced_ctrl:
        assert property (rd_now && mgmt_req.idx == 5'h12 ##1 !mgmt_rdata[7]
            |-> mode_cfg.ctrl0_bits == {mgmt_rdata[6], 2'b00, mgmt_rdata[5]}
            && !mode_cfg.autoneg_enable)
        else $error("forced mode control bits wrong");
    a_autodone_gate:
        assert property (rd_now && mgmt_req.idx == 5'h1f ##1 mgmt_rdata[12]
            |-> mode_cfg.autoneg_enable)
        else $error("done shown without negotiation");
    a_crs_rx_only:
        assert property ((!rx_active && !mode_cfg.crs_on_tx) [*4] |-> !crs)
        else $error("carrier sense without receive");
    a_soft_mask:
        assert property (soft_reset |=> !mgmt_irq)
        else $error("interrupt after soft reset");
    a_irq_fall_cause:
        assert property ($fell(mgmt_irq) |-> $past(soft_reset
            || mgmt_req.we && mgmt_req.idx == 5'h1e
            || mgmt_req.re && mgmt_req.idx == 5'h1d))
        else $error("interrupt dropped without cause");
    a_addr_kept:
        assert property (soft_reset && !mgmt_req.we
            |=> $stable(mgmt_device_address))
        else $error("address lost on soft reset");
endmodule
bind pvm_regs pvm_regs_checker pvm_regs_checker_i (.sys_clk(sys_clk),
    .rst_n(rst_n), .soft_reset(soft_reset), .mgmt_req(mgmt_req),
    .mgmt_rdata(mgmt_rdata), .rx_active(rx_active),
    .mgmt_device_address(mgmt_device_address), .mode_cfg(mode_cfg),
    .energy_detect_powerdown_enable(energy_detect_powerdown_enable),
    .rx_pll_reference_hold(rx_pll_reference_hold), .crs(crs),
    .mgmt_irq(mgmt_irq));
`default_nettype wire

// file: testbench/pvm_mgmt_master.sv
// management master model issuing register requests
`timescale 1ns/1ps
`default_nettype none
module pvm_mgmt_master
    import pvm_pkg::*;
(
    input wire logic sys_clk,
    output var pvm_pkg::pvm_req_t mgmt_req,
    input wire logic [15:0] mgmt_rdata
);
    // ----
    // requests
    // ----
    function automatic logic [15:0] keep(input logic [4:0] idx);
        case (idx)
            5'h11: keep = 16'h2000;
            5'h1b: keep = 16'h040f;
            5'h1e: keep = 16'h00ff;
            default: keep = 16'hffff;
        endcase
    endfunction
    initial mgmt_req = '0;
    task automatic wr(input logic [4:0] idx, input logic [15:0] d);
        logic [15:0] w;
        w = d & keep(idx);
        if (idx == 5'h1f) w[11:5] = 7'h02;
        // undefined mode is never sent, so the call is dropped
        if (idx == 5'h12 && w[7:5] == 3'h6) return;
        @(negedge sys_clk);
        mgmt_req <= '{we: 1'b1, re: 1'b0, idx: idx, wdata: w};
        @(negedge sys_clk);
        mgmt_req <= '0;
    endtask
    task automatic rd(input logic [4:0] idx, output logic [15:0] d);
        @(negedge sys_clk);
        mgmt_req <= '{we: 1'b0, re: 1'b1, idx: idx, wdata: 16'h0000};
        @(negedge sys_clk);
        mgmt_req <= '0;
        d = mgmt_rdata;
    endtask
endmodule
`default_nettype wire

// file: testbench/pvm_regs_test.sv
// self-checking bench for the vendor register bank
`timescale 1ns/1ps
`default_nettype none
module pvm_regs_test;
    import pvm_pkg::*;
    // ----
    // harness
    // ----
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic soft_reset = 1'b0;
    logic tx_active = 1'b0;
    logic rx_active = 1'b0;
    pvm_line_t line_in = '0;
    pvm_req_t mgmt_req;
    pvm_cfg_t mode_cfg;
    logic [15:0] mgmt_rdata;
    logic [15:0] got;
    logic [4:0] addr;
    logic [3:0] ce;
    logic [3:0] cm;
    logic edpd, pll_hold, crs, mgmt_irq;
    int err_total = 0;
    int compares = 0;
    always #12.5 sys_clk = ~sys_clk;
    // short quiet window keeps the run brief
    pvm_regs #(.ENERGY_TMO_CYC(100)) pvm_regs_i (.sys_clk(sys_clk),
        .rst_n(rst_n), .soft_reset(soft_reset), .mgmt_req(mgmt_req),
        .mgmt_rdata(mgmt_rdata), .line_in(line_in), .tx_active(tx_active),
        .rx_active(rx_active), .mgmt_device_address(addr),
        .mode_cfg(mode_cfg), .energy_detect_powerdown_enable(edpd),
        .rx_pll_reference_hold(pll_hold), .crs(crs), .mgmt_irq(mgmt_irq));
    pvm_mgmt_master pvm_mgmt_master_i (.sys_clk(sys_clk),
        .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rc(input logic [4:0] i, input logic [15:0] m,
                      input logic [15:0] e);
        pvm_mgmt_master_i.rd(i, got);
        chk(got & m, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        give_verdict;
    end
    initial begin
        cyc(10);
        rst_n = 1'b1;
        rc(5'h11, 16'h2002, 16'h0002);
        rc(5'h12, 16'h00ff, 16'h00e1);
        rc(5'h1b, 16'h040f, 16'h000b);
        rc(5'h1e, 16'h00ff, 16'h0000);
        rc(5'h05, 16'hffff, 16'h0000);
        chk({11'h0, addr}, 16'h0001);
        cyc(120);
        rc(5'h11, 16'h0002, 16'h0000);
        line_in.energy_seen = 1'b1;
        cyc(5);
        rc(5'h1d, 16'h00fe, 16'h0080);
        line_in.energy_seen = 1'b0;
        cyc(120);
        soft_reset = 1'b1;
        cyc(1);
        soft_reset = 1'b0;
        rc(5'h11, 16'h0002, 16'h0000);
        $display("test reset and energy done");
        pvm_mgmt_master_i.wr(5'h11, 16'h2000);
        rc(5'h11, 16'h2000, 16'h2000);
        pvm_mgmt_master_i.wr(5'h1b, 16'h0404);
        rc(5'h1b, 16'h040f, 16'h040b);
        chk({14'h0, edpd, pll_hold}, 16'h0003);
        line_in.polarity_reversed = 1'b1;
        line_in.link_up = 1'b1;
        cyc(4);
        rc(5'h1b, 16'h0010, 16'h0010);
        $display("test control bits done");
        pvm_mgmt_master_i.wr(5'h1e, 16'h00ff);
        // every event source except energy, link dropped, 100 full resolved
        line_in = 11'h37e;
        cyc(5);
        chk({15'h0, mgmt_irq}, 16'h0001);
        rc(5'h1d, 16'h00fe, 16'h007e);
        chk({15'h0, mgmt_irq}, 16'h0000);
        rc(5'h1d, 16'h00fe, 16'h0000);
        rc(5'h1f, 16'h101c, 16'h1018);
        pvm_mgmt_master_i.wr(5'h1e, 16'h0000);
        line_in.remote_fault = 1'b0;
        cyc(4);
        line_in.remote_fault = 1'b1;
        cyc(5);
        chk({15'h0, mgmt_irq}, 16'h0000);
        rc(5'h1d, 16'h0020, 16'h0020);
        $display("test interrupts done");
        tx_active = 1'b1;
        for (int m = 0; m < 8; m++) begin
            pvm_mgmt_master_i.wr(5'h12, {8'h0, m[2:0], 5'h01});
            cyc(5);
            if (m != 6) begin
                ce = (m < 4) ? {m[1], 2'b00, m[0]} : (m == 7) ? 4'h4 : 4'hc;
                cm = (m == 7) ? 4'h6 : 4'hf;
                chk({12'h0, mode_cfg.ctrl0_bits & cm}, {12'h0, ce});
                chk({15'h0, mode_cfg.autoneg_enable}, {15'h0, m > 3});
                if (m > 3)
                    chk({12'h0, mode_cfg.adv_bits}, m == 7 ? 16'hf : 16'h4);
                if (m > 1 && m < 6)
                    chk({15'h0, crs}, {15'h0, m == 2 || m == 4});
                rc(5'h1f, 16'h1000, m > 3 ? 16'h1000 : 16'h0000);
            end
        end
        pvm_mgmt_master_i.wr(5'h12, 16'h0069);
        rx_active = 1'b1;
        cyc(5);
        chk({15'h0, crs}, 16'h0001);
        $display("test modes done");
        soft_reset = 1'b1;
        cyc(1);
        soft_reset = 1'b0;
        rc(5'h12, 16'h00ff, 16'h0069);
        chk({11'h0, addr}, 16'h0009);
        rst_n = 1'b0;
        cyc(10);
        rst_n = 1'b1;
        rc(5'h12, 16'h00ff, 16'h00e1);
        rc(5'h11, 16'h0002, 16'h0002);
        $display("test resets done");
        give_verdict;
    end
endmodule
`default_nettype wire
